// *** pif_codec_model.sv ***
// codec stand-in driving bit clock, frame sync and both pcm lines
// assumes the bench calls frame() once per sample period
`default_nettype none
module pif_codec_model #(parameter int HALF_NS = 24) (
  output var logic bit_clk_o,
  output var logic frame_sync_o,
  output var logic send_o,
  output var logic recv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bit_clk_o = 1'b1;
    frame_sync_o = 1'b0;
    send_o = 1'b1;
    recv_o = 1'b0;
  end
  // clock rests high between frames so no stray falling edge shows
  task automatic frame(input logic [7:0] s, input logic [7:0] r);
    frame_sync_o = 1'b1;
    #(HALF_NS);
    for (int i = 7; i >= 0; i--) begin
      bit_clk_o = 1'b1;
      send_o = s[i]; // msb first
      recv_o = r[i];
      #(HALF_NS);
      bit_clk_o = 1'b0;
      #(HALF_NS);
      frame_sync_o = 1'b0;
    end
    bit_clk_o = 1'b1;
    // data past its hold time must not look like the last bit
    send_o = ~s[0];
    recv_o = ~r[0];
    #(HALF_NS * 4);
  endtask : frame
endmodule : pif_codec_model
`default_nettype wire

// *** pif_consts.svh ***
// constants for the pcm input frame control block
// assumes a 200 MHz core clock; included by its bare name
`ifndef PIF_CONSTS_SVH
`define PIF_CONSTS_SVH

`define PIF_CLK_PERIOD_NS     5
`define PIF_INIT_TIME_US      100
`define PIF_SAMPLE_BITS       8
`define PIF_LAST_BIT          3'h7
`define PIF_FIFO_DEPTH        8
`define PIF_LOAD_PULSE_CYCLES 4'h4
`define PIF_DAMP_DB           4'h6
`define PIF_PRESENCE_LEVEL    7'h10
`define PIF_SYNC_STAGES_IDX   2
`define PIF_PIN_BCLK          0
`define PIF_PIN_FSYNC         1
`define PIF_PIN_SEND          2
`define PIF_PIN_RECV          3
`define PIF_PIN_DAMP          4
`define PIF_PIN_START         5
`define PIF_PIN_ROLE          6
`define PIF_PIN_COUNT         7
`define PIF_PIN_IDLE          7'h3d

`endif

// *** pif_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
// assumes a single clock and an active-low asynchronous reset
`default_nettype none
module pif_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // stream
  pif_stream_if.fifo st
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign fill         = wr_ptr - rd_ptr;
  assign st.in_ready  = (fill != DEPTH[AW:0]);
  assign st.out_valid = (fill != '0);
  assign st.out_data  = mem[rd_ptr[AW-1:0]];
  assign push         = st.in_valid && st.in_ready;
  assign pop          = st.out_valid && st.out_ready;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // storage has no reset: the pointers alone say what is valid
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= st.in_data;
    end
  end
endmodule : pif_fifo
`default_nettype wire

// *** pif_frame_ctrl.sv ***
// pcm input capture, processing start and echo damper selection
// assumes all pins are asynchronous to core_clk_i and bit clock well below core rate
`default_nettype none
`include "pif_consts.svh"
module pif_frame_ctrl
  import pif_pkg::*;
#(
  parameter int INIT_CYCLES = ((`PIF_INIT_TIME_US * 1000) + `PIF_CLK_PERIOD_NS - 1)
                              / `PIF_CLK_PERIOD_NS,
  parameter int FIFO_DEPTH  = `PIF_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // serial pcm side
  input  wire logic       bit_clk_i,
  input  wire logic       frame_sync_i,
  input  wire logic       send_serial_in_i,
  input  wire logic       receive_serial_in_i,
  // control pins
  input  wire logic       echo_damp_select_i,
  input  wire logic       chip_role_select_i,
  input  wire logic       proc_start_n_i,
  output logic            load_detect_n_o,
  // processor side
  input  wire logic       sample_ready_i,
  output logic [7:0]      send_sample_o,
  output logic [7:0]      recv_sample_o,
  output logic            proc_launch_o,
  output logic            sample_overrun_o,
  output logic            send_damp_o,
  output logic            recv_damp_o,
  output logic [3:0]      damp_db_o
);
  localparam int SW = 2 * `PIF_SAMPLE_BITS;
  // idle levels: bit clock and start rest high, so release shows no false edge
  localparam logic [`PIF_PIN_COUNT-1:0] PIN_IDLE = `PIF_PIN_IDLE;

  logic [`PIF_PIN_COUNT-1:0] pin_s1;
  logic [`PIF_PIN_COUNT-1:0] pin_s2;
  logic                      bclk_prev;
  logic                      fsync_prev;
  logic                      start_prev;
  logic                      bclk_fall;
  logic                      fsync_rise;
  logic                      start_fall;
  pif_cap_state_t            cap_state;
  logic [2:0]                bit_cnt;
  logic [7:0]                send_shift;
  logic [7:0]                recv_shift;
  logic [7:0]                next_send_shift;
  logic [7:0]                next_recv_shift;
  logic                      word_done;
  logic                      pend;
  logic [SW-1:0]             pend_word;
  logic [3:0]                ld_cnt;
  logic                      take;
  logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt;
  logic                      init_done;
  logic [1:0]                boot_cnt;
  logic                      damp_sel;
  logic                      next_damp_sel;
  logic                      damp_en;
  logic                      send_present;
  logic                      recv_present;
  logic                      launch_ok;
  logic                      recv_only;
  logic                      next_send_damp;
  logic                      next_recv_damp;
  logic [3:0]                next_damp_db;

  pif_stream_if #(.WIDTH(SW)) st ();

  pif_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .st         (st.fifo)
  );

  // two-stage synchronisers; only stage two is read by logic
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
    end else begin
      pin_s1 <= {chip_role_select_i, proc_start_n_i, echo_damp_select_i,
                 receive_serial_in_i, send_serial_in_i, frame_sync_i, bit_clk_i};
      pin_s2 <= pin_s1;
    end
  end

  // previous values reset to the idle levels so release does not look like an edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bclk_prev  <= 1'b1;
      fsync_prev <= 1'b0;
      start_prev <= 1'b1;
    end else begin
      bclk_prev  <= pin_s2[`PIF_PIN_BCLK];
      fsync_prev <= pin_s2[`PIF_PIN_FSYNC];
      start_prev <= pin_s2[`PIF_PIN_START];
    end
  end

  assign bclk_fall  = bclk_prev && !pin_s2[`PIF_PIN_BCLK];
  assign fsync_rise = !fsync_prev && pin_s2[`PIF_PIN_FSYNC];
  assign start_fall = start_prev && !pin_s2[`PIF_PIN_START];

  assign next_send_shift = {send_shift[6:0], pin_s2[`PIF_PIN_SEND]};
  assign next_recv_shift = {recv_shift[6:0], pin_s2[`PIF_PIN_RECV]};
  assign word_done = (cap_state == PIF_CAPTURE) && bclk_fall && (bit_cnt == `PIF_LAST_BIT);

  // a sync rise restarts the frame, so a slipped frame recovers on the next sync
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_state <= PIF_IDLE;
      bit_cnt   <= 3'h0;
    end else if (fsync_rise) begin
      cap_state <= PIF_CAPTURE;
      bit_cnt   <= 3'h0;
    end else begin
      case (cap_state)
        PIF_IDLE: begin
          bit_cnt <= 3'h0;
        end
        PIF_CAPTURE: begin
          if (bclk_fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == `PIF_LAST_BIT) begin
              cap_state <= PIF_IDLE;
            end
          end
        end
        default: begin
          cap_state <= PIF_IDLE;
        end
      endcase
    end
  end

  // bits shift only inside a frame; a sync rise wins over a coincident clock fall,
  // as in the counter above, so shifter and count never drift apart
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      send_shift <= 8'h00;
      recv_shift <= 8'h00;
    end else if ((cap_state == PIF_CAPTURE) && bclk_fall && !fsync_rise) begin
      send_shift <= next_send_shift;
      recv_shift <= next_recv_shift;
    end
  end

  // completed word waits here when the fifo is full; a newer word replaces it
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend      <= 1'b0;
      pend_word <= '0;
    end else if (word_done) begin
      pend      <= 1'b1;
      pend_word <= {next_send_shift, next_recv_shift};
    end else if (st.in_ready) begin
      pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_overrun_o <= 1'b0;
    end else begin
      sample_overrun_o <= word_done && pend && !st.in_ready;
    end
  end

  assign st.in_valid  = pend;
  assign st.in_data   = pend_word;
  assign take         = st.out_valid && sample_ready_i && (ld_cnt == 4'h0);
  assign st.out_ready = sample_ready_i && (ld_cnt == 4'h0);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      send_sample_o <= 8'hff;
      recv_sample_o <= 8'hff;
    end else if (take) begin
      send_sample_o <= st.out_data[SW-1 -: 8];
      recv_sample_o <= st.out_data[7:0];
    end
  end

  // pulse length counter; no new load is taken while it runs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ld_cnt <= 4'h0;
    end else if (take) begin
      ld_cnt <= `PIF_LOAD_PULSE_CYCLES;
    end else if (ld_cnt != 4'h0) begin
      ld_cnt <= ld_cnt - 4'h1;
    end
  end

  // load detect stays low a few cycles so a start input can see it; registered,
  // so the pin never glitches
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_detect_n_o <= 1'b1;
    end else if (take) begin
      load_detect_n_o <= 1'b0;
    end else if (ld_cnt == 4'h1) begin
      load_detect_n_o <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_cnt <= '0;
    end else if (!init_done) begin
      init_cnt <= init_cnt + 1'b1;
    end
  end

  assign init_done = (init_cnt == INIT_CYCLES[$bits(init_cnt)-1:0]);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_cnt <= 2'h0;
    end else if (boot_cnt != 2'h3) begin
      boot_cnt <= boot_cnt + 2'h1;
    end
  end

  // a start fall inside the init window neither launches nor re-samples the select
  assign launch_ok = start_fall && init_done;

  // a slave has its select tied low, so it is treated as enabled regardless
  assign next_damp_sel = pin_s2[`PIF_PIN_DAMP] && !pin_s2[`PIF_PIN_ROLE];

  // caught once the synchroniser holds a post-reset value, then per start fall past the init window
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      damp_sel <= 1'b1;
    end else if ((boot_cnt == `PIF_SYNC_STAGES_IDX) || launch_ok) begin
      damp_sel <= next_damp_sel;
    end
  end

  assign damp_en = !damp_sel;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      proc_launch_o <= 1'b0;
    end else begin
      proc_launch_o <= launch_ok;
    end
  end

  // silence in mu-law is all ones; magnitude is the inverted low seven bits
  assign send_present = (~send_sample_o[6:0]) >= `PIF_PRESENCE_LEVEL;
  assign recv_present = (~recv_sample_o[6:0]) >= `PIF_PRESENCE_LEVEL;

  // receive-only talk damps the send path and every other case the receive path,
  // so with the damper on exactly one path is always damped
  assign recv_only = recv_present && !send_present;

  always_comb begin
    if (damp_en) begin
      next_send_damp = recv_only;
      next_recv_damp = !recv_only;
      next_damp_db   = `PIF_DAMP_DB;
    end else begin
      // damper off: neither path is touched
      next_send_damp = 1'b0;
      next_recv_damp = 1'b0;
      next_damp_db   = 4'h0;
    end
  end

  // decision follows the latest loaded samples and the held select
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      send_damp_o <= 1'b0;
      recv_damp_o <= 1'b0;
      damp_db_o   <= 4'h0;
    end else begin
      send_damp_o <= next_send_damp;
      recv_damp_o <= next_recv_damp;
      damp_db_o   <= next_damp_db;
    end
  end
endmodule : pif_frame_ctrl
`default_nettype wire

// *** pif_frame_ctrl_bench.sv ***
// self-checking bench for pif_frame_ctrl with a codec stand-in
// assumes pif_props is bound to the design by its own file
`default_nettype none
module pif_frame_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT = 50;
  logic core_clk_i, rst_n_i, bclk, fsync, sdat, rdat, sel, role, start_n, ready;
  logic ld_n, launch, ovr, sdamp, rdamp, ld_prev;
  logic [7:0] ssmp, rsmp;
  logic [3:0] db;
  int fails, checks_done, cycles, loads, ovrs;
  pif_frame_ctrl #(.INIT_CYCLES(INIT)) dut_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bit_clk_i(bclk), .frame_sync_i(fsync),
    .send_serial_in_i(sdat), .receive_serial_in_i(rdat), .echo_damp_select_i(sel),
    .chip_role_select_i(role), .proc_start_n_i(start_n), .load_detect_n_o(ld_n),
    .sample_ready_i(ready), .send_sample_o(ssmp), .recv_sample_o(rsmp),
    .proc_launch_o(launch), .sample_overrun_o(ovr), .send_damp_o(sdamp),
    .recv_damp_o(rdamp), .damp_db_o(db));
  pif_codec_model codec_u (.bit_clk_o(bclk), .frame_sync_o(fsync), .send_o(sdat), .recv_o(rdat));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  always @(negedge core_clk_i) begin
    cycles++;
    if (ovr === 1'b1) ovrs++;
    if (ld_prev === 1'b1 && ld_n === 1'b0) loads++;
    ld_prev = ld_n;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic start_once(input logic s, input logic ro, input logic [3:0] exp_db);
    int n;
    n = 0;
    sel = s;
    role = ro;
    repeat (8) @(negedge core_clk_i);
    start_n = 1'b0;
    repeat (8) begin
      @(negedge core_clk_i);
      if (launch === 1'b1) n++;
    end
    start_n = 1'b1;
    repeat (3) @(negedge core_clk_i);
    check("launch", 8'(n), 8'h1);
    check("db", {4'h0, db}, {4'h0, exp_db});
  endtask : start_once
  task automatic load_frame(input logic [7:0] s, input logic [7:0] r, input logic sd);
    int n;
    n = loads;
    codec_u.frame(s, r);
    repeat (12) @(negedge core_clk_i);
    check("loads", 8'(loads - n), 8'h1);
    check("send", ssmp, s);
    check("recv", rsmp, r);
    check("send damp", {7'h0, sdamp}, {7'h0, sd});
    check("recv damp", {7'h0, rdamp}, {7'h0, ~sd});
  endtask : load_frame
  task automatic t_init();
    int n;
    n = 0;
    sel = 1'b0;
    start_n = 1'b0;
    repeat (12) begin
      @(negedge core_clk_i);
      if (launch === 1'b1) n++;
    end
    start_n = 1'b1;
    check("early launch", 8'(n), 8'h0);
    check("early db", {4'h0, db}, 8'h00);
    repeat (INIT) @(negedge core_clk_i);
    $display("test init done");
  endtask : t_init
  task automatic t_damp();
    start_once(1'b0, 1'b0, 4'h6);
    check("silent damp", {6'h0, sdamp, rdamp}, 8'h01);
    load_frame(8'hf1, 8'h2c, 1'b1);
    // 8'hef sits exactly on the presence threshold
    load_frame(8'hf1, 8'hef, 1'b1);
    load_frame(8'h2c, 8'h2c, 1'b0);
    load_frame(8'h2c, 8'hf0, 1'b0);
    sel = 1'b1;
    repeat (20) @(negedge core_clk_i);
    check("held db", {4'h0, db}, 8'h06);
    start_once(1'b1, 1'b0, 4'h0);
    check("off damp", {6'h0, sdamp, rdamp}, 8'h00);
    start_once(1'b1, 1'b1, 4'h6);
    start_once(1'b0, 1'b0, 4'h6);
    $display("test damp done");
  endtask : t_damp
  task automatic t_fill();
    int n;
    n = loads;
    ready = 1'b0;
    for (int i = 1; i <= 10; i++) codec_u.frame(8'(i), 8'(255 - i));
    repeat (10) @(negedge core_clk_i);
    check("held loads", 8'(loads - n), 8'h0);
    check("overruns", 8'(ovrs), 8'h1);
    ready = 1'b1;
    repeat (80) @(negedge core_clk_i);
    check("drained", 8'(loads - n), 8'h9);
    check("last send", ssmp, 8'h0a);
    check("last recv", rsmp, 8'hf5);
    $display("test fill done");
  endtask : t_fill
  task automatic t_loop();
    int n;
    n = 0;
    sel = 1'b0; // damper on while cancelling echo
    role = 1'b0; // single chip
    // board loop: load detect wired straight back to the start input
    fork
      codec_u.frame(8'h2c, 8'h2c);
      repeat (115) begin
        @(negedge core_clk_i);
        start_n = ld_n;
        if (launch === 1'b1) n++;
      end
    join
    check("loop launch", 8'(n), 8'h1);
    check("loop db", {4'h0, db}, 8'h06);
    check("loop damp", {6'h0, sdamp, rdamp}, 8'h01);
    $display("test loop done");
  endtask : t_loop
  initial begin
    rst_n_i = 1'b0;
    sel = 1'b1;
    role = 1'b0;
    start_n = 1'b1;
    ready = 1'b1;
    ld_prev = 1'b1;
    repeat (10) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    check("idle load", {7'h0, ld_n}, 8'h01);
    check("idle send", ssmp, 8'hff);
    check("idle db", {4'h0, db}, 8'h00);
    $display("test reset done");
    t_init();
    t_damp();
    t_fill();
    t_loop();
    close_out();
  end
endmodule : pif_frame_ctrl_bench
`default_nettype wire

// *** pif_frame_ctrl_properties.sv ***
// assertions on the pins of pif_frame_ctrl
// assumes it is bound into every pif_frame_ctrl instance
`default_nettype none
module pif_props #(parameter int INIT_CYCLES = 50) (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       echo_damp_select_i,
  input wire logic       chip_role_select_i,
  input wire logic       proc_start_n_i,
  input wire logic       load_detect_n_o,
  input wire logic [7:0] send_sample_o,
  input wire logic [7:0] recv_sample_o,
  input wire logic       proc_launch_o,
  input wire logic       send_damp_o,
  input wire logic       recv_damp_o,
  input wire logic [3:0] damp_db_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] age;
  logic        s_live;
  logic        r_live;
  logic        on;
  assign s_live = (~send_sample_o[6:0]) >= 7'h10;
  assign r_live = (~recv_sample_o[6:0]) >= 7'h10;
  assign on = damp_db_o == 4'h6;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      age <= 16'h0;
    end else if (age != 16'hffff) begin
      age <= age + 16'h1;
    end
  end
  AST_LD_WIDTH: assert property ($fell(load_detect_n_o) |-> (!load_detect_n_o) [*4]
    ##1 load_detect_n_o) else $error("load pulse width wrong");
  AST_ONE_PATH: assert property ((send_damp_o ^ recv_damp_o) == on
    && !(send_damp_o && recv_damp_o) && (on || damp_db_o == 4'h0)) else $error("damp paths");
  AST_SEND_DAMP: assert property ((on && r_live && !s_live) [*2] |-> send_damp_o)
    else $error("send path not damped");
  AST_RECV_DAMP: assert property ((on && !(r_live && !s_live)) [*2] |-> recv_damp_o)
    else $error("recv path not damped");
  AST_LAUNCH: assert property (proc_launch_o |-> !$past(proc_start_n_i, 2)
    && $past(proc_start_n_i, 7)) else $error("launch without start fall");
  AST_INIT: assert property (age < INIT_CYCLES |-> !proc_launch_o)
    else $error("launch in init window");
  AST_SEL_HOLD: assert property ($changed(damp_db_o) |-> $past(proc_launch_o) || age < 16'h8)
    else $error("select taken without launch");
  AST_SEL_TAKE: assert property (proc_launch_o |=> damp_db_o ==
    ((echo_damp_select_i && !chip_role_select_i) ? 4'h0 : 4'h6)) else $error("select ignored");
endmodule : pif_props
bind pif_frame_ctrl pif_props #(.INIT_CYCLES(INIT_CYCLES)) chk_u (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .echo_damp_select_i(echo_damp_select_i),
  .chip_role_select_i(chip_role_select_i), .proc_start_n_i(proc_start_n_i),
  .load_detect_n_o(load_detect_n_o), .send_sample_o(send_sample_o),
  .recv_sample_o(recv_sample_o), .proc_launch_o(proc_launch_o),
  .send_damp_o(send_damp_o), .recv_damp_o(recv_damp_o), .damp_db_o(damp_db_o));
`default_nettype wire

// *** pif_pkg.sv ***
// types shared by the pcm input frame control block
// assumes nothing beyond a sv compiler
`default_nettype none
package pif_pkg;
  typedef enum logic {PIF_IDLE, PIF_CAPTURE} pif_cap_state_t;
endpackage : pif_pkg
`default_nettype wire

// *** pif_stream_if.sv ***
// valid/ready stream between the capture logic and the sample fifo
// assumes both ends run on the same core clock
`default_nettype none
interface pif_stream_if #(parameter int WIDTH = 16);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : pif_stream_if
`default_nettype wire
